/* File: logic/flyback_pwm_pkg.sv */
// Constants and carrier types for the flyback PWM sequencer
package flyback_pwm_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_FREQ_KHZ = 100;
  localparam int PERIOD_CYC = 1000000 / (OSC_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int MAX_DUTY_PCT = 75;
  localparam int MAX_ON_CYC = PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int JITTER_PCT = 4;
  localparam int JITTER_CYC = PERIOD_CYC * JITTER_PCT / 100;
  localparam int JITTER_PERIOD_US = 4000;
  localparam int JITTER_STEP_CYC =
    JITTER_PERIOD_US * 1000 / (4 * JITTER_CYC * CLK_PERIOD_NS);
  localparam int MIN_OFF_NS = 156;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_NORMAL_NS = 220;
  localparam int BLANK_NORMAL_CYC = (BLANK_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_BURST_NS = 180;
  localparam int BLANK_BURST_CYC = (BLANK_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_STEP_US = 300;
  localparam int SS_STEP_CYC = SS_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int SS_TIME_MS = 10;
  localparam int SS_TIME_CYC = SS_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SS_STEPS = 32;
  localparam int SS_STEP_W = $clog2(SS_STEPS);
  localparam int SS_TICK_W = 16;
  localparam int SS_TOTAL_W = 20;
  localparam int OSC_W = 10;
  localparam int JIT_W = 6;
  localparam int JIT_TICK_W = 12;
  localparam logic signed [JIT_W-1:0] JIT_MAX = JIT_W'(JITTER_CYC);
  localparam logic signed [JIT_W-1:0] JIT_MIN = -JIT_MAX;
  localparam logic [7:0] REG_CTRL_ADR = 8'h00;
  localparam logic [7:0] REG_STATUS_ADR = 8'h04;
  localparam logic [7:0] REG_JITTER_ADR = 8'h08;
  localparam int CTRL_SWITCH_BIT = 0;
  localparam int CTRL_JITTER_BIT = 1;
  localparam logic CTRL_SWITCH_RST = 1'h1;
  localparam logic CTRL_JITTER_RST = 1'h1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_BURST_BIT = 4;
  localparam int STAT_GATE_BIT = 5;
  localparam int STAT_STEP_LSB = 8;

  typedef enum logic [2:0] {
    PWR_OFF = 3'b001,
    PWR_RUN = 3'b010,
    PWR_RESTART = 3'b100
  } power_type;

  typedef struct packed {
    logic supplyOn;
    logic supplyOff;
    logic dutyTrip;
    logic peakTrip;
    logic burstTrip;
    logic fault;
    logic burst;
  } cmp_type;

  typedef struct packed {
    logic gateOn;
    logic rampReset;
    logic senseBlank;
    logic biasEnable;
    logic startupCellEnable;
    logic referenceEnable;
    logic softStartDone;
  } drive_type;
endpackage : flyback_pwm_pkg

/* File: logic/flyback_pwm_sequencer.sv */
// Flyback controller sequencing: lockout, soft start, oscillator, PWM latch
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module flyback_pwm_sequencer
  import flyback_pwm_pkg::*;
#(
  parameter int SsStepCyc = SS_STEP_CYC,
  parameter int SsTimeCyc = SS_TIME_CYC
)
(
  input wire logic core_clk, // 40 MHz clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire cmp_type cmpIn, // Comparator and mode levels
  output drive_type driveOut, // Gate and bias controls
  input wire logic wbCyc, // Wishbone cycle
  input wire logic wbStb, // Wishbone strobe
  input wire logic wbWe, // Wishbone write enable
  input wire logic [7:0] wbAdr, // Wishbone byte address
  input wire logic [3:0] wbSel, // Wishbone byte selects
  input wire logic [31:0] wbDatIn, // Wishbone write data
  output logic [31:0] wbDatOut, // Wishbone read data
  output logic wbAck // Wishbone acknowledge
);

  typedef struct packed {
    cmp_type sync1;
    cmp_type sync2;
    power_type power;
    logic [OSC_W-1:0] oscCnt;
    logic latch;
    logic gate;
    logic rampReset;
    logic blank;
    logic bias;
    logic startCell;
    logic refEn;
    logic [SS_TICK_W-1:0] ssTick;
    logic [SS_STEP_W-1:0] ssStep;
    logic [SS_TOTAL_W-1:0] ssTotal;
    logic ssDone;
    logic signed [JIT_W-1:0] jitOffset;
    logic jitDown;
    logic [JIT_TICK_W-1:0] jitTick;
    logic ctrlSwitch;
    logic ctrlJitter;
    logic ack;
    logic [31:0] rdData;
  } state_type;

  state_type s_q;
  state_type s_d;
  cmp_type c;
  logic wrap;
  logic blankNow;
  logic allowed;
  logic tripAny;
  logic jitOn;
  logic wbReq;
  int periodLen;
  int blankCyc;
  int softOn;

  // Comparators only act through the second synchroniser stage
  assign c = s_q.sync2;
  assign wbReq = wbCyc && wbStb && !s_q.ack;

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = cmpIn;
    s_d.sync2 = s_q.sync1;

    // Supply sequencing
    unique case (s_q.power)
      PWR_OFF:
      begin
        if (c.supplyOn)
        begin
          s_d.power = PWR_RUN;
        end
      end
      PWR_RUN:
      begin
        // Only the off comparator returns to off, giving hysteresis; a fault goes to restart
        if (c.supplyOff)
        begin
          s_d.power = PWR_OFF;
        end
        else if (c.fault)
        begin
          s_d.power = PWR_RESTART;
        end
      end
      PWR_RESTART:
      begin
        if (c.supplyOff)
        begin
          s_d.power = PWR_OFF;
        end
        else if (!c.fault)
        begin
          s_d.power = PWR_RUN;
        end
      end
      default:
      begin
        s_d.power = PWR_OFF;
      end
    endcase

    // Soft start: held cleared outside normal operation, so each entry starts at zero
    if (s_d.power != PWR_RUN)
    begin
      s_d.ssTick = '0;
      s_d.ssStep = '0;
      s_d.ssTotal = '0;
      s_d.ssDone = 1'b0;
    end
    else if (!s_q.ssDone)
    begin
      s_d.ssTotal = s_q.ssTotal + 1'b1;
      if (int'(s_q.ssTotal) >= SsTimeCyc - 1)
      begin
        s_d.ssDone = 1'b1;
      end
      if (int'(s_q.ssTick) >= SsStepCyc - 1)
      begin
        s_d.ssTick = '0;
        if (s_q.ssStep != '1)
        begin
          s_d.ssStep = s_q.ssStep + 1'b1;
        end
      end
      else
      begin
        s_d.ssTick = s_q.ssTick + 1'b1;
      end
    end

    // Jitter: triangular sweep between the two extremes
    jitOn = s_d.ssDone && s_d.power == PWR_RUN && s_q.ctrlJitter;
    if (!jitOn)
    begin
      s_d.jitOffset = '0;
      s_d.jitDown = 1'b0;
      s_d.jitTick = '0;
    end
    else if (int'(s_q.jitTick) >= JITTER_STEP_CYC - 1)
    begin
      s_d.jitTick = '0;
      if (s_q.jitDown)
      begin
        if (s_q.jitOffset == JIT_MIN)
        begin
          s_d.jitDown = 1'b0;
          s_d.jitOffset = s_q.jitOffset + 1'b1;
        end
        else
        begin
          s_d.jitOffset = s_q.jitOffset - 1'b1;
        end
      end
      else
      begin
        if (s_q.jitOffset == JIT_MAX)
        begin
          s_d.jitDown = 1'b1;
          s_d.jitOffset = s_q.jitOffset - 1'b1;
        end
        else
        begin
          s_d.jitOffset = s_q.jitOffset + 1'b1;
        end
      end
    end
    else
    begin
      s_d.jitTick = s_q.jitTick + 1'b1;
    end

    // Oscillator; the >= compare survives a period shrinking mid-count
    periodLen = PERIOD_CYC + int'(s_q.jitOffset);
    wrap = int'(s_q.oscCnt) >= periodLen - 1;
    s_d.oscCnt = wrap ? '0 : s_q.oscCnt + 1'b1;

    // Blanking covers the minimum-off delay plus the spike window
    blankCyc = c.burst ? BLANK_BURST_CYC : BLANK_NORMAL_CYC;
    blankNow = int'(s_q.oscCnt) < MIN_OFF_CYC + blankCyc;
    softOn = int'(s_q.ssStep) * MAX_ON_CYC / SS_STEPS;

    tripAny = 1'b0;
    if (!blankNow)
    begin
      if (c.dutyTrip)
      begin
        tripAny = 1'b1;
      end
      if (c.peakTrip)
      begin
        tripAny = 1'b1;
      end
      if (c.burstTrip && c.burst)
      begin
        tripAny = 1'b1;
      end
    end
    if (!s_q.ssDone && int'(s_q.oscCnt) >= softOn)
    begin
      tripAny = 1'b1;
    end
    if (int'(s_q.oscCnt) >= MAX_ON_CYC - 1)
    begin
      tripAny = 1'b1;
    end

    // PWM latch: set on the oscillator pulse, otherwise any trip clears it
    allowed = s_d.power == PWR_RUN && s_q.ctrlSwitch && !c.supplyOff;
    if (wrap)
    begin
      s_d.latch = allowed;
    end
    else if (tripAny)
    begin
      s_d.latch = 1'b0;
    end
    s_d.gate = s_d.latch && allowed && int'(s_d.oscCnt) >= MIN_OFF_CYC
      && int'(s_d.oscCnt) < MAX_ON_CYC;
    s_d.rampReset = int'(s_d.oscCnt) >= MAX_ON_CYC;
    s_d.blank = int'(s_d.oscCnt) < MIN_OFF_CYC + blankCyc;

    // Bias follows the gate while bursting; reference stays up until power returns to off
    s_d.bias = s_d.power == PWR_RUN && (!c.burst || s_d.gate);
    s_d.startCell = s_d.power == PWR_OFF;
    s_d.refEn = s_d.power != PWR_OFF;

    // Register slave: ack one cycle after the request, dropped the next
    s_d.ack = wbReq;
    s_d.rdData = '0;
    if (wbReq)
    begin
      if (wbWe && wbSel[0] && wbAdr == REG_CTRL_ADR)
      begin
        s_d.ctrlSwitch = wbDatIn[CTRL_SWITCH_BIT];
        s_d.ctrlJitter = wbDatIn[CTRL_JITTER_BIT];
      end
      if (!wbWe)
      begin
        unique case (wbAdr)
          REG_CTRL_ADR:
          begin
            s_d.rdData[CTRL_SWITCH_BIT] = s_q.ctrlSwitch;
            s_d.rdData[CTRL_JITTER_BIT] = s_q.ctrlJitter;
          end
          REG_STATUS_ADR:
          begin
            s_d.rdData[STAT_STATE_LSB +: 3] = s_q.power;
            s_d.rdData[STAT_DONE_BIT] = s_q.ssDone;
            s_d.rdData[STAT_BURST_BIT] = c.burst;
            s_d.rdData[STAT_GATE_BIT] = s_q.gate;
            s_d.rdData[STAT_STEP_LSB +: SS_STEP_W] = s_q.ssStep;
          end
          REG_JITTER_ADR:
          begin
            s_d.rdData = 32'(s_q.jitOffset);
          end
          default:
          begin
            s_d.rdData = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.power <= PWR_OFF;
      s_q.startCell <= 1'b1;
      s_q.ctrlSwitch <= CTRL_SWITCH_RST;
      s_q.ctrlJitter <= CTRL_JITTER_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign driveOut.gateOn = s_q.gate;
  assign driveOut.rampReset = s_q.rampReset;
  assign driveOut.senseBlank = s_q.blank;
  assign driveOut.biasEnable = s_q.bias;
  assign driveOut.startupCellEnable = s_q.startCell;
  assign driveOut.referenceEnable = s_q.refEn;
  assign driveOut.softStartDone = s_q.ssDone;
  assign wbDatOut = s_q.rdData;
  assign wbAck = s_q.ack;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_ramp_release;
    $fell(s_q.rampReset);
  endsequence

  sequence s_gate_start;
    $rose(s_q.gate);
  endsequence

  a_lockout_gate: assert property (
    (s_q.power != PWR_RUN) |-> !s_q.gate)
    else $error("gate on outside normal operation");

  a_bias_startcell: assert property (
    $rose(s_q.bias) |-> !s_q.startCell && s_q.power == PWR_RUN)
    else $error("bias on while startup cell still on");

  a_hysteresis_hold: assert property (
    (s_q.power == PWR_RUN && !c.supplyOff && !c.fault) |=> s_q.power == PWR_RUN)
    else $error("left normal operation without off indication");

  a_soft_clear: assert property (
    $rose(s_q.power == PWR_RUN) |-> s_q.ssStep == '0 && !s_q.ssDone)
    else $error("soft start did not start from step zero");

  a_restart_bias: assert property (
    (s_q.power == PWR_RESTART) |-> !s_q.bias)
    else $error("bias on during auto restart");

  a_restart_exit: assert property (
    (s_q.power == PWR_RESTART && !c.fault && !c.supplyOff) |=> s_q.power == PWR_RUN)
    else $error("auto restart not left after fault cleared");

  a_burst_bias: assert property (
    ($past(c.burst) && !s_q.gate) |-> !s_q.bias && (s_q.power == PWR_OFF || s_q.refEn))
    else $error("bias on while idle in burst mode");

  a_duty_trip: assert property (
    (s_q.gate && c.dutyTrip && !blankNow) |=> !s_q.gate)
    else $error("duty comparator did not end on-time");

  a_ramp_release: assert property (
    s_ramp_release |-> s_q.oscCnt == '0)
    else $error("ramp released away from period start");

  a_min_delay: assert property (
    s_ramp_release |-> !s_q.gate [*7])
    else $error("gate on within minimum delay");

  a_soft_step: assert property (
    (s_q.power == PWR_RUN && $past(s_q.power) == PWR_RUN && s_q.ssStep != $past(s_q.ssStep))
    |-> s_q.ssStep == SS_STEP_W'($past(s_q.ssStep) + 1'b1))
    else $error("soft start step skipped");

  a_max_duty: assert property (
    s_q.gate |-> int'(s_q.oscCnt) < MAX_ON_CYC)
    else $error("gate on beyond maximum duty");

  a_jitter_gate: assert property (
    !s_q.ssDone |-> s_q.jitOffset == '0)
    else $error("jitter active during soft start");

  a_peak_trip: assert property (
    (s_q.gate && c.peakTrip && !blankNow) |=> !s_q.gate)
    else $error("peak limit did not end on-time");

  a_blank_start: assert property (
    s_gate_start |-> s_q.blank)
    else $error("sense not blanked at on-time start");

  a_burst_trip: assert property (
    (s_q.gate && c.burstTrip && c.burst && !blankNow) |=> !s_q.gate)
    else $error("burst limit did not end on-time");

endmodule : flyback_pwm_sequencer

/* File: testbench/comparator_model.sv */
// Far-side model: sense current ramp and comparator levels seen by the sequencer
`timescale 1ns/1ps
module comparator_model
  import flyback_pwm_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic gateOn, // Gate enable from the sequencer
  input wire logic spike, // Adds a turn-on spike seen by the peak comparator only
  input wire logic [9:0] fbLvl, // Ramp count at which feedback trips
  input wire logic [9:0] peakLvl, // Ramp count at which the peak limit trips
  input wire logic [9:0] burstLvl, // Ramp count at which the burst limit trips
  output logic dutyTrip, // Sense above feedback
  output logic peakTrip, // Sense above peak limit
  output logic burstTrip // Sense above burst limit
);
  logic [9:0] ramp = 10'h0;
  initial dutyTrip = 1'b0;
  initial peakTrip = 1'b0;
  initial burstTrip = 1'b0;
  // Current flows only while the switch conducts, so every trip falls with the gate
  always @(posedge core_clk)
  begin
    ramp <= gateOn ? ramp + 10'h1 : 10'h0;
    dutyTrip <= gateOn && ramp >= fbLvl;
    peakTrip <= gateOn && (ramp >= peakLvl || (spike && ramp < 10'h4));
    burstTrip <= gateOn && ramp >= burstLvl;
  end
endmodule : comparator_model

/* File: testbench/tb.sv */
// Self-checking bench for the flyback PWM sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nFail++; \
  $display("wrong value %s expected %0d seen %0d", nm, e, g); end end
module tb;
  import flyback_pwm_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sOn = 1'b0, sOff = 1'b1, flt = 1'b0, brst = 1'b0, spike = 1'b1;
  logic dTrip, pTrip, bTrip;
  logic [9:0] fbLvl = 10'h3ff, peakLvl = 10'h3ff, burstLvl = 10'h3ff;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0] wbAdr = 8'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut;
  cmp_type cmpIn;
  drive_type driveOut;
  int nFail = 0, numChecks = 0, cycles = 0, hi = 0, sinceRise = 0;
  int widths[$], periods[$];
  logic gPrev = 1'b0;
  assign cmpIn = {sOn, sOff, dTrip, pTrip, bTrip, flt, brst};
  always #12.5 core_clk = ~core_clk;
  flyback_pwm_sequencer #(.SsStepCyc(20), .SsTimeCyc(800)) dut (.core_clk(core_clk),
    .reset_n(reset_n), .cmpIn(cmpIn), .driveOut(driveOut), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck));
  comparator_model far (.core_clk(core_clk), .gateOn(driveOut.gateOn), .spike(spike),
    .fbLvl(fbLvl), .peakLvl(peakLvl), .burstLvl(burstLvl), .dutyTrip(dTrip),
    .peakTrip(pTrip), .burstTrip(bTrip));
  task final_report();
    if (nFail == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Pulse widths and rise-to-rise periods, in clock cycles
  always @(posedge core_clk)
  begin
    cycles++;
    sinceRise++;
    if (driveOut.gateOn === 1'b1)
      hi++;
    else if (hi > 0)
    begin
      widths.push_back(hi);
      hi = 0;
    end
    if (driveOut.gateOn === 1'b1 && gPrev !== 1'b1)
    begin
      periods.push_back(sinceRise);
      sinceRise = 0;
    end
    gPrev = driveOut.gateOn;
    if (cycles > 40000)
    begin
      nFail++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
    output logic [31:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hf;
    wbDatIn <= d;
    // No local limit: only the cycle ceiling ends a hung transfer
    do
    begin
      @(posedge core_clk);
    end
    while (wbAck !== 1'b1);
    q = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  // Width of the last complete pulse, after levels have settled for one period
  task automatic meas(output int w);
    tick(400);
    widths.delete();
    tick(450);
    w = widths.size() ? widths[widths.size() - 1] : 0;
  endtask : meas
  // Trip seen through two sync flops plus the gate register, never before blanking ends
  function automatic logic inR(input int v, input int lvl, input int blank);
    int e;
    e = (lvl + 4 > blank + 1) ? lvl + 4 : blank + 1;
    return v >= e - 2 && v <= e + 2;
  endfunction : inR
  task automatic waitGate(input logic v);
    while (driveOut.gateOn !== v)
    begin
      @(posedge core_clk);
    end
  endtask : waitGate
  initial
  begin
    int w, lvl, j;
    logic [31:0] q;
    void'($urandom(52303));
    tick(10);
    reset_n <= 1'b1;
    @(posedge core_clk);
    `CHK("gateOn", 1'b0, driveOut.gateOn)
    `CHK("startCell", 1'b1, driveOut.startupCellEnable)
    wb(1'b0, REG_CTRL_ADR, 32'h0, q);
    `CHK("ctrl", 32'h3, q)
    wb(1'b1, REG_STATUS_ADR, 32'hff, q);
    wb(1'b0, REG_STATUS_ADR, 32'h0, q);
    `CHK("state", 3'b001, q[2:0])
    wb(1'b0, 8'h20, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    sOff <= 1'b0;
    sOn <= 1'b1;
    tick(6);
    `CHK("bias", 1'b1, driveOut.biasEnable)
    `CHK("cell", 1'b0, driveOut.startupCellEnable)
    `CHK("ref", 1'b1, driveOut.referenceEnable)
    `CHK("step0 pulses", 0, widths.size())
    sOn <= 1'b0;
    wb(1'b0, REG_JITTER_ADR, 32'h0, q);
    `CHK("jitter early", 32'h0, q)
    widths.delete();
    tick(700);
    w = 0;
    foreach (widths[i])
      if (widths[i] > w)
        w = widths[i];
    // Last soft step allows 31/32 of the maximum on count, from the delay end
    lvl = MAX_ON_CYC * (SS_STEPS - 1) / SS_STEPS - MIN_OFF_CYC + 1;
    `CHK("soft width", 1'b1, w > 0 && w <= lvl)
    `CHK("soft early", 1'b0, driveOut.softStartDone)
    tick(110);
    `CHK("soft done", 1'b1, driveOut.softStartDone)
    `CHK("bias held", 1'b1, driveOut.biasEnable)
    meas(w);
    `CHK("max duty", 1'b1, w >= 291 && w <= 293)
    `CHK("period", 1'b1, periods[$] >= 384 && periods[$] <= 416)
    waitGate(1'b1);
    waitGate(1'b0);
    `CHK("ramp held", 1'b1, driveOut.rampReset)
    `CHK("blank late", 1'b0, driveOut.senseBlank)
    waitGate(1'b1);
    `CHK("ramp free", 1'b0, driveOut.rampReset)
    `CHK("blank early", 1'b1, driveOut.senseBlank)
    repeat (4)
    begin
      lvl = 20 + $urandom % 230;
      fbLvl <= 10'(lvl);
      meas(w);
      `CHK("duty width", 1'b1, inR(w, lvl, BLANK_NORMAL_CYC))
      fbLvl <= 10'h3ff;
      lvl = 20 + $urandom % 230;
      peakLvl <= 10'(lvl);
      meas(w);
      `CHK("peak width", 1'b1, inR(w, lvl, BLANK_NORMAL_CYC))
      peakLvl <= 10'h3ff;
    end
    fbLvl <= 10'h0;
    meas(w);
    `CHK("blank normal", 1'b1, inR(w, 0, BLANK_NORMAL_CYC))
    brst <= 1'b1;
    meas(w);
    `CHK("blank burst", 1'b1, inR(w, 0, BLANK_BURST_CYC))
    fbLvl <= 10'h3ff;
    burstLvl <= 10'd60;
    meas(w);
    `CHK("burst limit", 1'b1, inR(w, 60, BLANK_BURST_CYC))
    waitGate(1'b0);
    waitGate(1'b1);
    tick(3);
    `CHK("burst bias on", 1'b1, driveOut.biasEnable)
    waitGate(1'b0);
    tick(20);
    `CHK("burst bias off", 1'b0, driveOut.biasEnable)
    `CHK("burst ref", 1'b1, driveOut.referenceEnable)
    brst <= 1'b0;
    meas(w);
    `CHK("burst gated", 1'b1, w >= 291 && w <= 293)
    burstLvl <= 10'h3ff;
    wb(1'b0, REG_JITTER_ADR, 32'h0, q);
    j = $signed(q);
    `CHK("jitter", 1'b1, j != 0 && j >= -16 && j <= 16)
    wb(1'b1, REG_CTRL_ADR, 32'h0, q);
    meas(w);
    `CHK("switch off", 0, w)
    wb(1'b1, REG_CTRL_ADR, 32'h3, q);
    flt <= 1'b1;
    tick(6);
    `CHK("restart bias", 1'b0, driveOut.biasEnable)
    wb(1'b0, REG_STATUS_ADR, 32'h0, q);
    `CHK("restart state", 3'b100, q[2:0])
    flt <= 1'b0;
    tick(6);
    wb(1'b0, REG_STATUS_ADR, 32'h0, q);
    `CHK("resume state", 3'b010, q[2:0])
    `CHK("resume step", 5'h0, q[12:8])
    `CHK("resume done", 1'b0, q[3])
    tick(300);
    sOff <= 1'b1;
    tick(6);
    `CHK("off gate", 1'b0, driveOut.gateOn)
    `CHK("off bias", 1'b0, driveOut.biasEnable)
    `CHK("off cell", 1'b1, driveOut.startupCellEnable)
    sOff <= 1'b0;
    sOn <= 1'b1;
    tick(6);
    wb(1'b0, REG_STATUS_ADR, 32'h0, q);
    `CHK("new step", 5'h0, q[12:8])
    `CHK("new state", 3'b010, q[2:0])
    final_report();
  end
endmodule : tb
